// ===== common/adc_cmpq_defines.svh
// Register offsets, field positions and reset values of the compare and queue block
`ifndef ADC_CMPQ_DEFINES_SVH
`define ADC_CMPQ_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CMP_A_CTRL 8'h00
`define OFS_CMP_B_CTRL 8'h04
`define OFS_Q_STATUS   8'h08
`define OFS_Q_DATA     8'h0c
`define OFS_CMP_A_THR  8'h10
`define OFS_CMP_B_THR  8'h14
`define OFS_CMP_A_MASK 8'h18
`define OFS_CMP_B_MASK 8'h1c
`define OFS_CONFIG     8'h20
`define OFS_CHAN_BASE  8'h80
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMP_ON_BIT   7
`define CMP_IRQ_BIT  6
`define CMP_EVT_BIT  5
`define CMP_ID_LSB   8
`define CMP_ID_MSB   12
`define SEL_BTWN     4
`define SEL_HIHI     3
`define SEL_HILO     2
`define SEL_LOHI     1
`define SEL_LOLO     0
`define THR_HI_LSB   16
`define Q_EN_BIT     31
`define Q_CH0_BIT    24
`define Q_IRQ_BIT    23
`define Q_RDY_BIT    22
`define Q_OVF_BIT    21
`define Q_CNT_LSB    8
`define Q_CNT_MSB    15
`define Q_SIGN_BIT   7
`define Q_ID_LSB     0
`define Q_ID_MSB     2
`define FRACTIONAL_FORMAT_BIT    0
// ----------------------------------------
// Values
// ----------------------------------------
`define Q_CH0_ID     3'h0
`define WORD_RESET   32'h0000_0000
`define NUM_CMP      2
`define NUM_INPUTS   32
`endif

// ===== common/adc_cmpq_pkg.sv
// Types shared by the compare and queue block
`default_nettype none
package adc_cmpq_pkg;
  typedef struct packed {
    logic        valid;
    logic [4:0]  input_id;
    logic [15:0] data;
  } conv_result_t;

  typedef struct packed {
    logic       on;
    logic       irq_en;
    logic [4:0] sel;
  } cmp_cfg_t;
endpackage
`default_nettype wire

// ===== logic/adc_result_compare_and_queue.sv
// Digital comparators, result queue and result registers behind a plain register port
// Operation
// [RULE1] Between select: event when low threshold <= result < high threshold
// [RULE2] At-or-above-high select: event when high threshold <= result
// [RULE3] Below-high select: event when result < high threshold
// [RULE4] At-or-above-low select: event when low threshold <= result
// [RULE5] Below-low select: event when result < low threshold; zero selects nothing
// [RULE6] Second comparator has the same five selects, evaluated identically
// [RULE7] Second comparator watches inputs 0 to 31, reports input in bits 12:8
// [RULE8] On-bit enables comparator; writing zero disables and clears its event
// [RULE9] Interrupt enable raises comparator interrupt while event flag is set
// [RULE10] Event flag set by hardware, cleared by reading the input id field
// [RULE11] Queue enable gates all writes into the queue
// [RULE12] Channel 0 select decides whether channel 0 results are queued
// [RULE13] Queued results still land in the channel result register
// [RULE14] Queue interrupt enable raises interrupt once data ready is set
// [RULE15] Data ready stays while queue holds data, clears when emptied
// [RULE16] Circular queue; overflow sets error flag, cleared by status read
// [RULE17] Status count reports number of entries held
// [RULE18] Sign flag reflects sign of word presented by queue data
// [RULE19] Channel identifier field reads 000 for channel 0
// [RULE20] Queue data register presents oldest queued value
// [RULE21] Result register reads follow current fractional format setting
// [RULE22] Alternate input results read from primary input result register
// [RULE23] Each queue data read removes one entry unless empty
//
// Design decisions made here: the address-and-strobe port and the address map.
`include "adc_cmpq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_result_compare_and_queue #(
  parameter int RES_W   = 12,
  parameter int Q_DEPTH = 16
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       nrst_in,
  input  wire adc_cmpq_pkg::conv_result_t result_in,
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic [31:0]                reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output var  logic [31:0]                reg_rdata_out,
  output var  logic [1:0]                 cmp_irq_out,
  output var  logic                       queue_irq_out
);
  localparam int PW = $clog2(Q_DEPTH);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] fmt_word(input logic [RES_W-1:0] raw,
                                           input logic fractional_format);
    // Fractional form is left justified, integer form right justified
    fmt_word = fractional_format ? {raw, {(32-RES_W){1'b0}}}
                     : {{(32-RES_W){1'b0}}, raw};
  endfunction

  function automatic logic cmp_hit(input logic [4:0] sel, input logic [31:0] d,
                                   input logic [15:0] lo, input logic [15:0] hi);
    logic lo_le;
    logic hi_le;
    lo_le   = ({16'h0000, lo} <= d);
    hi_le   = ({16'h0000, hi} <= d);
    cmp_hit = (sel[`SEL_BTWN] && lo_le && !hi_le)  // RULE1
            | (sel[`SEL_HIHI] && hi_le)            // RULE2
            | (sel[`SEL_HILO] && !hi_le)           // RULE3
            | (sel[`SEL_LOHI] && lo_le)            // RULE4
            | (sel[`SEL_LOLO] && !lo_le);          // RULE5
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  adc_cmpq_pkg::cmp_cfg_t cmp_cfg_reg  [`NUM_CMP];
  logic                   cmp_evt_reg  [`NUM_CMP];
  logic [4:0]             cmp_id_reg   [`NUM_CMP];
  logic [31:0]            cmp_thr_reg  [`NUM_CMP];
  logic [31:0]            cmp_mask_reg [`NUM_CMP];
  logic [RES_W-1:0]       chan_reg     [`NUM_INPUTS];
  logic [RES_W-1:0]       q_mem        [Q_DEPTH];
  logic [PW-1:0]          q_wr_ptr_reg;
  logic [PW-1:0]          q_rd_ptr_reg;
  logic [7:0]             q_count_reg;
  logic                   q_en_reg;
  logic                   q_ch0_reg;
  logic                   q_irq_en_reg;
  logic                   q_ovf_reg;
  logic                   fractional_format_reg;

  // ----------------------------------------
  // Incoming result
  // ----------------------------------------
  wire logic [RES_W-1:0] res_raw  = result_in.data[RES_W-1:0];
  wire logic [31:0]      res_word = {{(32-RES_W){1'b0}}, res_raw};
  wire logic [4:0]       res_id   = result_in.input_id;

  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  wire adc_cmpq_pkg::cmp_cfg_t cfg_next  [`NUM_CMP];
  wire logic [31:0]            ctrl_word [`NUM_CMP];
  wire logic [4:0]             id_next   [`NUM_CMP];
  wire logic [`NUM_CMP-1:0]    fire;
  wire logic [`NUM_CMP-1:0]    evt_next;
  wire logic [`NUM_CMP-1:0]    wr_thr;
  wire logic [`NUM_CMP-1:0]    wr_mask;
  wire logic [`NUM_CMP-1:0]    rd_ctrl;

  for (genvar k = 0; k < `NUM_CMP; k++) begin : cmp_g
    localparam logic [7:0] CTRL_OFS = (k == 0) ? `OFS_CMP_A_CTRL : `OFS_CMP_B_CTRL;
    localparam logic [7:0] THR_OFS  = (k == 0) ? `OFS_CMP_A_THR : `OFS_CMP_B_THR;
    localparam logic [7:0] MASK_OFS = (k == 0) ? `OFS_CMP_A_MASK : `OFS_CMP_B_MASK;
    wire logic wr_ctrl = reg_wr_in && (reg_addr_in == CTRL_OFS);
    wire logic [15:0] lo = cmp_thr_reg[k][`THR_HI_LSB-1:0];
    wire logic [15:0] hi = cmp_thr_reg[k][31:`THR_HI_LSB];
    assign rd_ctrl[k] = reg_rd_in && (reg_addr_in == CTRL_OFS);
    assign wr_thr[k]  = reg_wr_in && (reg_addr_in == THR_OFS);
    assign wr_mask[k] = reg_wr_in && (reg_addr_in == MASK_OFS);
    assign cfg_next[k] = wr_ctrl ? {reg_wdata_in[`CMP_ON_BIT], reg_wdata_in[`CMP_IRQ_BIT],
                                    reg_wdata_in[`SEL_BTWN:`SEL_LOLO]}
                                 : cmp_cfg_reg[k];
    // Same hit function for both comparators
    assign fire[k] = cmp_cfg_reg[k].on && result_in.valid  // RULE6
                   && cmp_mask_reg[k][res_id]               // RULE7
                   && cmp_hit(cmp_cfg_reg[k].sel, res_word, lo, hi);
    // Disable wins over a hit in the same cycle; a hit wins over a read clear
    assign evt_next[k] = cfg_next[k].on                           // RULE8
                       && (fire[k] || (cmp_evt_reg[k] && !rd_ctrl[k]));  // RULE10
    assign id_next[k] = fire[k] ? res_id : cmp_id_reg[k];  // RULE7
    assign ctrl_word[k] = {{(31-`CMP_ID_MSB){1'b0}}, cmp_id_reg[k],
                           cmp_cfg_reg[k].on, cmp_cfg_reg[k].irq_en,
                           cmp_evt_reg[k], cmp_cfg_reg[k].sel};
  end

  // ----------------------------------------
  // Result queue
  // ----------------------------------------
  wire logic wr_status = reg_wr_in && (reg_addr_in == `OFS_Q_STATUS);
  wire logic rd_status = reg_rd_in && (reg_addr_in == `OFS_Q_STATUS);
  wire logic rd_data   = reg_rd_in && (reg_addr_in == `OFS_Q_DATA);
  wire logic q_empty   = (q_count_reg == 8'h00);
  wire logic q_full    = (q_count_reg == 8'(Q_DEPTH));
  wire logic q_push    = q_en_reg && q_ch0_reg        // RULE11 RULE12
                       && result_in.valid && (res_id == 5'h00);
  wire logic q_pop     = rd_data && !q_empty;         // RULE23
  // Full queue overwrites its oldest entry
  wire logic q_over    = q_push && q_full && !q_pop;  // RULE16
  wire logic q_take    = q_push && !q_over;
  wire logic [7:0] q_count_next = q_count_reg + {7'h00, q_take} - {7'h00, q_pop};  // RULE17
  wire logic q_en_next     = wr_status ? reg_wdata_in[`Q_EN_BIT] : q_en_reg;
  wire logic q_irq_en_next = wr_status ? reg_wdata_in[`Q_IRQ_BIT] : q_irq_en_reg;
  wire logic q_ch0_next    = wr_status ? reg_wdata_in[`Q_CH0_BIT] : q_ch0_reg;
  wire logic q_ovf_next    = q_over || (q_ovf_reg && !rd_status);  // RULE16
  // Oldest entry, shown in the format in force at read time
  wire logic [31:0] q_word = q_empty ? `WORD_RESET
                                     : fmt_word(q_mem[q_rd_ptr_reg], fractional_format_reg);  // RULE20

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic [7:0] chan_off = reg_addr_in - `OFS_CHAN_BASE;
  wire logic       chan_sel = (reg_addr_in >= `OFS_CHAN_BASE) && (chan_off[1:0] == 2'h0);
  logic [31:0] status_word;
  logic [31:0] rdata_next;

  always_comb begin
    status_word = `WORD_RESET;
    status_word[`Q_EN_BIT]  = q_en_reg;
    status_word[`Q_CH0_BIT] = q_ch0_reg;
    status_word[`Q_IRQ_BIT] = q_irq_en_reg;
    status_word[`Q_RDY_BIT] = !q_empty;                         // RULE15
    status_word[`Q_OVF_BIT] = q_ovf_reg;                        // RULE16
    status_word[`Q_CNT_MSB:`Q_CNT_LSB] = q_count_reg;           // RULE17
    status_word[`Q_SIGN_BIT] = q_word[31];                      // RULE18
    status_word[`Q_ID_MSB:`Q_ID_LSB] = `Q_CH0_ID;               // RULE19
  end

  always_comb begin
    rdata_next = `WORD_RESET;
    if (chan_sel) begin
      rdata_next = fmt_word(chan_reg[chan_off[6:2]], fractional_format_reg);  // RULE21
    end else begin
      case (reg_addr_in)
        `OFS_CMP_A_CTRL: rdata_next = ctrl_word[0];
        `OFS_CMP_B_CTRL: rdata_next = ctrl_word[1];
        `OFS_Q_STATUS:   rdata_next = status_word;
        `OFS_Q_DATA:     rdata_next = q_word;
        `OFS_CMP_A_THR:  rdata_next = cmp_thr_reg[0];
        `OFS_CMP_B_THR:  rdata_next = cmp_thr_reg[1];
        `OFS_CMP_A_MASK: rdata_next = cmp_mask_reg[0];
        `OFS_CMP_B_MASK: rdata_next = cmp_mask_reg[1];
        `OFS_CONFIG:     rdata_next = {31'h0000_0000, fractional_format_reg};
        default:         rdata_next = `WORD_RESET;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int k = 0; k < `NUM_CMP; k++) begin
        cmp_cfg_reg[k]  <= '0;
        cmp_evt_reg[k]  <= 1'b0;
        cmp_id_reg[k]   <= 5'h00;
        cmp_thr_reg[k]  <= `WORD_RESET;
        cmp_mask_reg[k] <= `WORD_RESET;
      end
      cmp_irq_out <= 2'h0;
    end else begin
      for (int k = 0; k < `NUM_CMP; k++) begin
        cmp_cfg_reg[k] <= cfg_next[k];
        cmp_evt_reg[k] <= evt_next[k];
        cmp_id_reg[k]  <= id_next[k];
        if (wr_thr[k]) begin
          cmp_thr_reg[k] <= reg_wdata_in;
        end
        if (wr_mask[k]) begin
          cmp_mask_reg[k] <= reg_wdata_in;
        end
        cmp_irq_out[k] <= evt_next[k] && cfg_next[k].irq_en;  // RULE9
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_wr_ptr_reg  <= '0;
      q_rd_ptr_reg  <= '0;
      q_count_reg   <= 8'h00;
      q_en_reg      <= 1'b0;
      q_ch0_reg     <= 1'b0;
      q_irq_en_reg  <= 1'b0;
      q_ovf_reg     <= 1'b0;
      fractional_format_reg     <= 1'b0;
      queue_irq_out <= 1'b0;
      reg_rdata_out <= `WORD_RESET;
    end else begin
      if (q_push) begin
        q_wr_ptr_reg <= PW'((q_wr_ptr_reg + 1'b1) % Q_DEPTH);
      end
      if (q_pop || q_over) begin
        q_rd_ptr_reg <= PW'((q_rd_ptr_reg + 1'b1) % Q_DEPTH);
      end
      q_count_reg   <= q_count_next;
      q_en_reg      <= q_en_next;
      q_ch0_reg     <= q_ch0_next;
      q_irq_en_reg  <= q_irq_en_next;
      q_ovf_reg     <= q_ovf_next;
      if (reg_wr_in && (reg_addr_in == `OFS_CONFIG)) begin
        fractional_format_reg <= reg_wdata_in[`FRACTIONAL_FORMAT_BIT];
      end
      queue_irq_out <= q_irq_en_next && (q_count_next != 8'h00);  // RULE14
      // Read data valid only in the cycle after the strobe
      reg_rdata_out <= reg_rd_in ? rdata_next : `WORD_RESET;
    end
  end

  // Raw storage; format applied on read so a format change needs no rewrite
  always_ff @(posedge ref_clk_in) begin
    if (q_push) begin
      q_mem[q_wr_ptr_reg] <= res_raw;
    end
    if (result_in.valid) begin
      chan_reg[res_id] <= res_raw;  // RULE13 RULE22
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_btwn_event: assert property (  // RULE1
    (cmp_cfg_reg[0].on && cmp_cfg_reg[0].sel[`SEL_BTWN] && result_in.valid
     && cmp_mask_reg[0][res_id] && res_word >= {16'h0000, cmp_thr_reg[0][`THR_HI_LSB-1:0]}
     && res_word < {16'h0000, cmp_thr_reg[0][31:`THR_HI_LSB]} && cfg_next[0].on)
    |=> cmp_evt_reg[0] && cmp_id_reg[0] == $past(res_id))
    else $error("between hit did not latch event");

  a_hihi_event: assert property (  // RULE2
    (cmp_cfg_reg[1].on && cmp_cfg_reg[1].sel[`SEL_HIHI] && result_in.valid
     && cmp_mask_reg[1][res_id] && res_word >= {16'h0000, cmp_thr_reg[1][31:`THR_HI_LSB]}
     && cfg_next[1].on) |=> cmp_evt_reg[1])
    else $error("high hit did not latch event");

  a_zero_select: assert property (  // RULE5
    (cmp_cfg_reg[0].sel == 5'h00 && !cmp_evt_reg[0]) |=> !cmp_evt_reg[0])
    else $error("event without any select");

  a_cmp_b_id: assert property (  // RULE7
    fire[1] |=> ctrl_word[1][`CMP_ID_MSB:`CMP_ID_LSB] == $past(res_id))
    else $error("comparator input id wrong");

  a_off_clears: assert property (  // RULE8
    !cmp_cfg_reg[0].on |-> !cmp_evt_reg[0] && !cmp_irq_out[0])
    else $error("event held while disabled");

  a_read_clears: assert property (  // RULE10
    (rd_ctrl[1] && !fire[1]) |=> !cmp_evt_reg[1])
    else $error("id read did not clear event");

  a_queue_gate: assert property (  // RULE11
    !q_en_reg |=> $stable(q_wr_ptr_reg))
    else $error("queue written while disabled");

  a_pop_count: assert property (  // RULE23
    (rd_data && !q_empty && !q_push) |=> q_count_reg == $past(q_count_reg) - 8'h01)
    else $error("data read did not remove entry");

  a_ovf_set: assert property (  // RULE16
    (q_push && q_full && !rd_data) |=> q_ovf_reg && q_count_reg == 8'(Q_DEPTH))
    else $error("overflow not flagged");

  a_queue_irq: assert property (  // RULE14
    (q_irq_en_reg && !q_empty && !wr_status && !rd_data) |=> queue_irq_out)
    else $error("queue interrupt missing");
endmodule
`default_nettype wire

// ===== sim/adc_core_model.sv
// Model of the converter cores that hand conversion results to the block
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  input  wire logic                       ref_clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       start_in,
  input  wire logic [4:0]                 id_in,
  input  wire logic [15:0]                data_in,
  output var  adc_cmpq_pkg::conv_result_t result_out
);
  // ----------------------------------------
  // Result launch
  // ----------------------------------------
  // Outside a valid cycle id and data flip, so a stale value cannot pass as fresh
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_out <= '0;
    end else if (start_in) begin
      result_out <= {1'b1, id_in, data_in};
    end else begin
      result_out <= {1'b0, ~result_out.input_id, ~result_out.data};
    end
  end
endmodule
`default_nettype wire

// ===== sim/adc_result_compare_and_queue_test.sv
// Self-checking bench for the compare and queue block
`include "adc_cmpq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module adc_result_compare_and_queue_test;
  // ----------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------
  localparam int QDEPTH = 16;
  logic                       ref_clk_in = 1'b0;
  logic                       nrst_in    = 1'b0;
  logic                       start      = 1'b0;
  logic [4:0]                 src_id     = 5'h00;
  logic [15:0]                src_data   = 16'h0000;
  adc_cmpq_pkg::conv_result_t result;
  logic [7:0]                 reg_addr   = 8'h00;
  logic [31:0]                reg_wdata  = 32'h0000_0000;
  logic                       reg_wr     = 1'b0;
  logic                       reg_rd     = 1'b0;
  logic [31:0]                rdata;
  logic [1:0]                 cmp_irq;
  logic                       queue_irq;
  logic [31:0]                rd_val;
  int                         err_total   = 0;
  int                         check_count = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  adc_core_model core (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .start_in(start), .id_in(src_id),
                       .data_in(src_data), .result_out(result));

  adc_result_compare_and_queue #(.RES_W(12), .Q_DEPTH(QDEPTH)) uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .result_in(result), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .cmp_irq_out(cmp_irq), .queue_irq_out(queue_irq));

  // ----------------------------------------
  // Bus and source tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd   <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic send(input logic [4:0] id, input logic [15:0] d);
    @(posedge ref_clk_in);
    start    <= 1'b1;
    src_id   <= id;
    src_data <= d;
    @(posedge ref_clk_in);
    start    <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask

  // Low threshold 0x100, high threshold 0x200
  function automatic logic hit(input int s, input logic [15:0] d);
    case (s)
      4:       hit = (d >= 16'h0100) && (d < 16'h0200);
      3:       hit = d >= 16'h0200;
      2:       hit = d < 16'h0200;
      1:       hit = d >= 16'h0100;
      default: hit = d < 16'h0100;
    endcase
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_map();
    rd(`OFS_CMP_A_CTRL);
    `CHK("ctrl a reset", 32'h0000_0000, rd_val)
    rd(`OFS_Q_DATA);
    `CHK("data reset", 32'h0000_0000, rd_val)
    wr(`OFS_Q_STATUS, 32'hffff_ffff);
    rd(`OFS_Q_STATUS);
    `CHK("status writable bits", 32'h8180_0000, rd_val)
    `CHK("q irq empty", 1'b0, queue_irq)
    wr(`OFS_CMP_B_CTRL, 32'hffff_ffff);
    rd(`OFS_CMP_B_CTRL);
    `CHK("ctrl b writable bits", 32'h0000_00df, rd_val)
    wr(`OFS_CMP_B_CTRL, 32'h0);
    wr(`OFS_Q_STATUS, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    `CHK("unmapped", 32'h0000_0000, rd_val)
  endtask

  task automatic test_compare();
    logic [15:0] vals [4] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200};
    logic [7:0]  ctrl;
    logic        e;
    for (int k = 0; k < 2; k++) begin
      ctrl = `OFS_CMP_A_CTRL + 8'(4 * k);
      wr(`OFS_CMP_A_THR + 8'(4 * k), 32'h0200_0100);
      wr(`OFS_CMP_A_MASK + 8'(4 * k), 32'hffff_ffff);
      for (int s = 0; s < 5; s++) begin
        wr(ctrl, 32'h0000_00c0 | (32'h1 << s));
        foreach (vals[v]) begin
          e = hit(s, vals[v]);
          send(5'd19, vals[v]);
          `CHK("cmp irq", e, cmp_irq[k])
          rd(ctrl);
          `CHK("cmp ctrl", {2'b11, e, 5'(1 << s)}, rd_val[7:0])
          if (e) `CHK("cmp id", 5'd19, rd_val[12:8])
          rd(ctrl);
          `CHK("cmp read clear", 1'b0, rd_val[5])
        end
      end
      wr(ctrl, 32'h0000_00c0);
      send(5'd19, 16'h0150);
      `CHK("no select irq", 1'b0, cmp_irq[k])
      wr(ctrl, 32'h0000_00c2);
      send(5'd3, 16'h0150);
      `CHK("hit before off", 1'b1, cmp_irq[k])
      wr(ctrl, 32'h0000_0042);
      // Look before any read, which would clear the event on its own
      #1;
      `CHK("off clears irq", 1'b0, cmp_irq[k])
      wr(ctrl, 32'h0000_00c2);
      rd(ctrl);
      `CHK("off clears event", 1'b0, rd_val[5])
      wr(ctrl, 32'h0);
    end
  endtask

  task automatic test_queue();
    wr(`OFS_Q_STATUS, 32'h8180_0000);
    for (int i = 0; i < 3; i++) send(5'd0, 16'h00a0 + 16'(i));
    send(5'd1, 16'h0555);
    `CHK("q irq", 1'b1, queue_irq)
    rd(`OFS_Q_STATUS);
    `CHK("status three", 32'h81c0_0300, rd_val)
    rd(`OFS_CHAN_BASE);
    `CHK("chan0 result", 32'h0000_00a2, rd_val)
    for (int i = 0; i < 3; i++) begin
      rd(`OFS_Q_DATA);
      `CHK("q data", 32'h0000_00a0 + 32'(i), rd_val)
      rd(`OFS_Q_STATUS);
      `CHK("q status pop", 32'h8180_0000 | 32'((2 - i) << 8) | (i < 2 ? 32'h0040_0000 : 32'h0), rd_val)
    end
    `CHK("q irq empty", 1'b0, queue_irq)
    rd(`OFS_Q_DATA);
    rd(`OFS_Q_STATUS);
    `CHK("empty pop", 32'h8180_0000, rd_val)
    wr(`OFS_Q_STATUS, 32'h8100_0000);
    send(5'd0, 16'h0011);
    `CHK("q irq masked", 1'b0, queue_irq)
    rd(`OFS_Q_DATA);
    wr(`OFS_Q_STATUS, 32'h0100_0000);
    send(5'd0, 16'h0022);
    rd(`OFS_Q_STATUS);
    `CHK("queue off", 32'h0100_0000, rd_val)
    wr(`OFS_Q_STATUS, 32'h8000_0000);
    send(5'd0, 16'h0033);
    rd(`OFS_Q_STATUS);
    `CHK("chan0 deselected", 32'h8000_0000, rd_val)
  endtask

  task automatic test_overflow_format();
    wr(`OFS_Q_STATUS, 32'h8100_0000);
    for (int i = 1; i <= QDEPTH + 1; i++) send(5'd0, 16'(i));
    rd(`OFS_Q_STATUS);
    `CHK("overflow", 32'h8160_0000 | 32'(QDEPTH << 8), rd_val)
    rd(`OFS_Q_STATUS);
    `CHK("overflow cleared", 32'h8140_0000 | 32'(QDEPTH << 8), rd_val)
    rd(`OFS_Q_DATA);
    `CHK("oldest overwritten", 32'h0000_0002, rd_val)
    repeat (QDEPTH - 1) rd(`OFS_Q_DATA);
    wr(`OFS_CONFIG, 32'h0000_0001);
    send(5'd0, 16'h0800);
    rd(`OFS_Q_STATUS);
    `CHK("sign", 32'h8140_0180, rd_val)
    rd(`OFS_Q_DATA);
    `CHK("fractional_format data", 32'h8000_0000, rd_val)
    rd(`OFS_CHAN_BASE);
    `CHK("fractional_format chan", 32'h8000_0000, rd_val)
    wr(`OFS_CONFIG, 32'h0);
    rd(`OFS_CHAN_BASE);
    `CHK("int chan", 32'h0000_0800, rd_val)
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    test_reset_map();
    test_compare();
    test_queue();
    test_overflow_format();
    finish_test();
  end

  // Whole run needs about 670 cycles; the 20000-cycle limit leaves wide margin
  initial begin
    #200000;
    err_total++;
    $display("Watchdog expired");
    finish_test();
  end
endmodule
`default_nettype wire
